// File: src/stepper_indexer_fault_control.sv
// Indexer, enable, sleep and protection control for a bipolar stepper driver
// Summary of operation
// - Clear held low resets logic, homes the table index, disables both bridges.
// - Advance pulses are ignored while clear is held low.
// - Enable low: bridges on, each rising advance edge moves the indexer.
// - Enable high: bridges off, outputs high impedance, advance ignored.
// - Sleep request low: bridges, charge pump, aux regulator and clocks all stop.
// - In sleep step, clear, enable and limit inputs are ignored until the request returns high.
// - Per-FET limit held past qualification time: FETs off, fault driven low.
// - After overcurrent trip stay off until clear or supply cycle.
// - High-side and low-side limits trip alike, independent of chopping sense.
// - Die over about 150 C: FETs off and fault driven low.
// - Thermal trip clears by itself when the die cools.
// - Supply below lockout threshold resets and disables all but the clocks; resumes above it.
// - Each index maps to a signed winding current pair.
//
// The register offsets and the plain strobed port were chosen for this implementation.
`default_nettype none
module stepper_indexer_fault_control #(
  parameter int OC_CYC = stepper_pkg::OC_QUAL_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic step_in,
  input wire logic chip_clear_n,
  input wire logic output_enable_bar,
  input wire logic low_power_request_n,
  input wire logic [2:0] step_mode,
  input wire logic [stepper_pkg::FET_N-1:0] fet_limit,
  input wire logic die_hot,
  input wire logic supply_low,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wr_data,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rd_data,
  output logic irq,
  output logic bridge_a_en,
  output logic bridge_b_en,
  output logic outputs_hiz,
  output logic charge_pump_run,
  output logic aux_regulator_en,
  output logic clocks_run,
  output logic signed [stepper_pkg::PCT_W-1:0] current_a,
  output logic signed [stepper_pkg::PCT_W-1:0] current_b,
  output logic [stepper_pkg::IDX_W-1:0] table_index,
  output logic error_flag_out_n_o,
  output logic error_flag_out_n_oe_n
);
  import stepper_pkg::*;

  localparam int CW = $clog2(OC_CYC + 1);

  if (OC_CYC < 1)
  begin : g_bad_cyc
    $error("OC_CYC must be at least one cycle");
  end

  logic [PIN_N-1:0] pins_s;
  logic step_s, clear_n_s, oe_bar_s, sleep_n_s, hot_s, low_s;
  logic [FET_N-1:0] lim_s;
  logic [2:0] mode_s;
  drv_state_e state, next_state;
  logic step_q, step_rise, step_take, step_drop;
  logic [IDX_W-1:0] next_index;
  logic [FET_N-1:0] oc_hit;
  logic oc_tripped, oc_q, hot_q, low_q, fault;
  logic [EV_N-1:0] status, mask, ev_set;

  pin_sync #(.W(PIN_N), .RST_VAL(PIN_RST)) u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .d({step_mode, fet_limit, supply_low, die_hot, low_power_request_n,
        output_enable_bar, chip_clear_n, step_in}),
    .q(pins_s)
  );

  assign {mode_s, lim_s, low_s, hot_s, sleep_n_s, oe_bar_s, clear_n_s, step_s} = pins_s;

  // Lockout wins over sleep since the supply is gone; sleep then masks clear
  always_comb
  begin
    if (low_s)
      next_state = ST_LOCKOUT;
    else if (!sleep_n_s)
      next_state = ST_SLEEP;
    else if (!clear_n_s)
      next_state = ST_CLEAR;
    else if (oc_tripped)
      next_state = ST_TRIPPED;
    else
      next_state = ST_RUN;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      state <= ST_CLEAR;
    else
      state <= next_state;
  end

  // Edge history always tracks the pin so waking never fakes an edge
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      step_q <= 1'b0;
    else
      step_q <= step_s;
  end

  assign step_rise = step_s & ~step_q;
  assign step_take = step_rise && state == ST_RUN && !oe_bar_s;
  assign step_drop = step_rise && !step_take && state != ST_SLEEP && state != ST_LOCKOUT;

  always_comb
  begin
    unique case (mode_s)
      MODE_FULL: next_index = {table_index[6:5] + {1'b0, table_index[4]}, FULL_OFS};
      MODE_HALF: next_index = table_index + 7'd16;
      MODE_4: next_index = table_index + 7'd8;
      MODE_8: next_index = table_index + 7'd4;
      MODE_16: next_index = table_index + 7'd2;
      default: next_index = table_index + 7'd1;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      table_index <= IDX_HOME;
    else if (state == ST_CLEAR || state == ST_LOCKOUT)
      table_index <= IDX_HOME;
    else if (step_take)
      table_index <= next_index;
  end

  current_table u_table (
    .core_clk(core_clk),
    .rst(rst),
    .idx(table_index),
    .cur_a(current_a),
    .cur_b(current_b)
  );

  // One qualification timer per FET; it holds in sleep and clears in other states outside run
  for (genvar i = 0; i < FET_N; i++)
  begin : g_oc
    logic [CW-1:0] cnt;
    always_ff @(posedge core_clk or posedge rst)
    begin
      if (rst)
        cnt <= '0;
      else if (state == ST_SLEEP)
        cnt <= cnt;
      else if (state != ST_RUN || !lim_s[i])
        cnt <= '0;
      else if (cnt != CW'(OC_CYC))
        cnt <= cnt + 1'b1;
    end
    assign oc_hit[i] = cnt == CW'(OC_CYC);
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      oc_tripped <= 1'b0;
    else if (state == ST_CLEAR || state == ST_LOCKOUT)
      oc_tripped <= 1'b0;
    else if (state == ST_RUN && |oc_hit)
      oc_tripped <= 1'b1;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      bridge_a_en <= 1'b0;
      bridge_b_en <= 1'b0;
      outputs_hiz <= 1'b1;
    end
    else
    begin
      bridge_a_en <= state == ST_RUN && !oe_bar_s && !hot_s;
      bridge_b_en <= state == ST_RUN && !oe_bar_s && !hot_s;
      outputs_hiz <= !(state == ST_RUN && !oe_bar_s && !hot_s);
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      charge_pump_run <= 1'b0;
      aux_regulator_en <= 1'b0;
      clocks_run <= 1'b0;
    end
    else
    begin
      charge_pump_run <= state != ST_SLEEP && state != ST_LOCKOUT;
      aux_regulator_en <= state != ST_SLEEP && state != ST_LOCKOUT;
      clocks_run <= state != ST_SLEEP;
    end
  end

  // Fault output is frozen in sleep and released under lockout
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      fault <= 1'b0;
    else if (state == ST_LOCKOUT)
      fault <= 1'b0;
    else if (state != ST_SLEEP)
      fault <= oc_tripped || hot_s;
  end

  assign error_flag_out_n_o = 1'b0;
  assign error_flag_out_n_oe_n = !fault;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      oc_q <= 1'b0;
      hot_q <= 1'b0;
      low_q <= 1'b0;
    end
    else
    begin
      oc_q <= oc_tripped;
      hot_q <= hot_s;
      low_q <= low_s;
    end
  end

  always_comb
  begin
    ev_set = '0;
    ev_set[EV_OC] = oc_tripped && !oc_q;
    ev_set[EV_HOT] = hot_s && !hot_q;
    ev_set[EV_LOW] = low_s && !low_q;
    ev_set[EV_DROP] = step_drop;
  end

  // Read clears, but an event in the same cycle survives
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      status <= STATUS_RST;
    else if (reg_rd && reg_addr == ADDR_STATUS)
      status <= ev_set;
    else
      status <= status | ev_set;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      mask <= MASK_RST;
    else if (reg_wr && reg_addr == ADDR_MASK)
      mask <= reg_wr_data[EV_N-1:0];
  end

  assign irq = |(status & mask);

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      reg_rd_data <= '0;
    else if (!reg_rd)
      reg_rd_data <= '0;
    else if (reg_addr == ADDR_STATUS)
      reg_rd_data <= {28'h0, status};
    else if (reg_addr == ADDR_MASK)
      reg_rd_data <= {28'h0, mask};
    else if (reg_addr == ADDR_STATE)
      reg_rd_data <= {14'h0, mode_s, fault, oc_tripped, hot_s, low_s, state, 1'b0, table_index};
    else
      reg_rd_data <= '0;
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  a_clear_home: assert property (state == ST_CLEAR |=> table_index == IDX_HOME && !bridge_a_en)
    else $error("clear did not home the index");
  a_clear_no_step: assert property (state == ST_CLEAR && step_rise |=> $stable(table_index))
    else $error("advance taken during clear");
  a_step_fine: assert property (step_take && mode_s == 3'h5 |=> table_index == 7'($past(table_index) + 1))
    else $error("fine step did not advance by one");
  a_enable_drive: assert property (state == ST_RUN && !oe_bar_s && !hot_s |=> bridge_a_en && !outputs_hiz)
    else $error("bridges not enabled");
  a_disable_hiz: assert property (oe_bar_s && step_rise |=> outputs_hiz && !bridge_b_en && $stable(table_index))
    else $error("disabled outputs not high impedance");
  a_sleep_off: assert property (state == ST_SLEEP |=> !charge_pump_run && !aux_regulator_en && !clocks_run)
    else $error("sleep left supplies running");
  a_sleep_freeze: assert property (state == ST_SLEEP ##1 state == ST_SLEEP |-> $stable(table_index))
    else $error("index moved in sleep");
  a_oc_trip: assert property (state == ST_RUN && |oc_hit |=> oc_tripped ##1 !error_flag_out_n_oe_n ##1 !bridge_a_en)
    else $error("overcurrent did not shut down");
  a_oc_hold: assert property (oc_tripped && state != ST_CLEAR && state != ST_LOCKOUT |=> oc_tripped)
    else $error("overcurrent latch released");
  a_hot_fault: assert property (hot_s && state == ST_RUN |=> !bridge_a_en && !error_flag_out_n_oe_n)
    else $error("thermal trip not acted on");
  a_hot_resume: assert property ($fell(hot_s) && state == ST_RUN && !oc_tripped && !oe_bar_s |=> bridge_a_en)
    else $error("no resume after cooling");
  a_lockout: assert property (low_s |=> state == ST_LOCKOUT ##1 table_index == IDX_HOME && !charge_pump_run)
    else $error("lockout did not reset");
  a_table_270: assert property (table_index == 7'd96 |=> current_a == 8'sd0 && current_b == -8'sd100)
    else $error("table entry wrong");

  c_step: cover property (step_take ##[1:20] step_take);
  c_oc: cover property (oc_tripped ##1 state == ST_CLEAR);
  c_sleep_wake: cover property (state == ST_SLEEP ##1 state == ST_RUN);
  c_lockout: cover property (state == ST_LOCKOUT);
endmodule
`default_nettype wire

// File: src/stepper_pkg.sv
// Shared constants and types for the stepper indexer and fault control
`default_nettype none
package stepper_pkg;
  localparam int CLK_HZ = 20_000_000;
  localparam int OC_QUAL_NS = 3000;
  localparam int OC_QUAL_CYC = (OC_QUAL_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int IDX_W = 7;
  localparam int FET_N = 8;
  localparam int PCT_W = 8;
  localparam int PIN_N = 17;
  localparam logic [PIN_N-1:0] PIN_RST = 17'h0000c;
  localparam logic [IDX_W-1:0] IDX_HOME = 7'h00;
  localparam logic [4:0] FULL_OFS = 5'h10;
  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_MASK = 4'h4;
  localparam logic [3:0] ADDR_STATE = 4'h8;
  localparam int EV_N = 4;
  localparam int EV_OC = 0;
  localparam int EV_HOT = 1;
  localparam int EV_LOW = 2;
  localparam int EV_DROP = 3;
  localparam logic [EV_N-1:0] STATUS_RST = 4'h0;
  localparam logic [EV_N-1:0] MASK_RST = 4'h0;
  localparam logic [2:0] MODE_FULL = 3'h0;
  localparam logic [2:0] MODE_HALF = 3'h1;
  localparam logic [2:0] MODE_4 = 3'h2;
  localparam logic [2:0] MODE_8 = 3'h3;
  localparam logic [2:0] MODE_16 = 3'h4;
  typedef enum logic [2:0] {ST_LOCKOUT, ST_SLEEP, ST_CLEAR, ST_TRIPPED, ST_RUN} drv_state_e;
endpackage
`default_nettype wire

// File: src/pin_sync.sv
// Two-stage synchroniser for a group of pin inputs
`default_nettype none
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      meta <= RST_VAL;
      q <= RST_VAL;
    end
    else
    begin
      meta <= d;
      q <= meta;
    end
  end
endmodule
`default_nettype wire

// File: src/current_table.sv
// Winding current lookup, registered output, signed percent of full scale
`default_nettype none
module current_table (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [stepper_pkg::IDX_W-1:0] idx,
  output logic signed [stepper_pkg::PCT_W-1:0] cur_a,
  output logic signed [stepper_pkg::PCT_W-1:0] cur_b
);
  import stepper_pkg::*;

  // Quarter wave, 33 points from 0 to 90 degrees
  function automatic logic [PCT_W-1:0] quarter(input logic [5:0] r);
    logic [PCT_W-1:0] v;
    v = 8'h64;
    unique case (r)
      6'h00: v = 8'h00;
      6'h01: v = 8'h05;
      6'h02: v = 8'h0a;
      6'h03: v = 8'h0f;
      6'h04: v = 8'h14;
      6'h05: v = 8'h18;
      6'h06: v = 8'h1d;
      6'h07: v = 8'h22;
      6'h08: v = 8'h26;
      6'h09: v = 8'h2b;
      6'h0a: v = 8'h2f;
      6'h0b: v = 8'h33;
      6'h0c: v = 8'h38;
      6'h0d: v = 8'h3c;
      6'h0e: v = 8'h3f;
      6'h0f: v = 8'h43;
      6'h10: v = 8'h47;
      6'h11: v = 8'h4a;
      6'h12: v = 8'h4d;
      6'h13: v = 8'h50;
      6'h14: v = 8'h53;
      6'h15: v = 8'h56;
      6'h16: v = 8'h58;
      6'h17: v = 8'h5a;
      6'h18: v = 8'h5c;
      6'h19: v = 8'h5e;
      6'h1a: v = 8'h60;
      6'h1b: v = 8'h61;
      6'h1c: v = 8'h62;
      6'h1d: v = 8'h63;
      default: v = 8'h64;
    endcase
    return v;
  endfunction

  function automatic logic signed [PCT_W-1:0] wave(input logic [IDX_W-1:0] k);
    logic [PCT_W-1:0] m;
    m = k[5] ? quarter(6'd32 - {1'b0, k[4:0]}) : quarter({1'b0, k[4:0]});
    return k[6] ? -$signed(m) : $signed(m);
  endfunction

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      cur_a <= 8'sh64;
      cur_b <= 8'sh00;
    end
    else
    begin
      cur_a <= wave(idx + 7'h20);
      cur_b <= wave(idx);
    end
  end
endmodule
`default_nettype wire

// File: tb/step_source.sv
// Step pulse source standing in for the motion controller
`default_nettype none
module step_source #(
  parameter int SETTLE_CYC = 20000
) (
  input wire logic core_clk,
  input wire logic low_power_request_n,
  output logic step_in
);
  timeunit 1ns;
  timeprecision 1ns;
  int awake_cyc = SETTLE_CYC;
  initial step_in = 1'b0;
  // Time since wake; a real controller holds off steps while the device settles
  always @(posedge core_clk)
    if (!low_power_request_n)
      awake_cyc <= 0;
    else if (awake_cyc < SETTLE_CYC)
      awake_cyc <= awake_cyc + 1;
  // Early skips the settle wait, used for the clear-hold and sleep-ignore cases
  task automatic pulse(input int n, input bit early);
    for (int i = 0; i < n; i++)
    begin
      while (!early && awake_cyc < SETTLE_CYC) @(posedge core_clk);
      @(posedge core_clk);
      step_in <= 1'b1;
      repeat (3) @(posedge core_clk);
      step_in <= 1'b0;
      repeat (3) @(posedge core_clk);
    end
  endtask
endmodule
`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench for the stepper indexer and fault control
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import stepper_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic chip_clear_n = 1'b0;
  logic output_enable_bar = 1'b0;
  logic low_power_request_n = 1'b1;
  logic [2:0] step_mode = MODE_HALF;
  logic [FET_N-1:0] fet_limit = '0;
  logic die_hot = 1'b0;
  logic supply_low = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wr_data = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rd_data;
  logic irq, bridge_a_en, bridge_b_en, outputs_hiz, charge_pump_run, aux_regulator_en, clocks_run;
  logic signed [PCT_W-1:0] current_a, current_b;
  logic [IDX_W-1:0] table_index;
  logic err_o, err_oe_n, step_in;
  logic [31:0] rd;
  int fail_count = 0;
  int compares = 0;
  int cycles = 0;
  // Open-drain fault line with board pull-up
  wire fault_pin = err_oe_n ? 1'b1 : err_o;

  stepper_indexer_fault_control #(.OC_CYC(4)) dut (.core_clk(core_clk), .rst(rst), .step_in(step_in),
    .chip_clear_n(chip_clear_n), .output_enable_bar(output_enable_bar), .low_power_request_n(low_power_request_n),
    .step_mode(step_mode), .fet_limit(fet_limit), .die_hot(die_hot), .supply_low(supply_low),
    .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rd_data(reg_rd_data),
    .irq(irq), .bridge_a_en(bridge_a_en), .bridge_b_en(bridge_b_en), .outputs_hiz(outputs_hiz),
    .charge_pump_run(charge_pump_run), .aux_regulator_en(aux_regulator_en), .clocks_run(clocks_run),
    .current_a(current_a), .current_b(current_b), .table_index(table_index),
    .error_flag_out_n_o(err_o), .error_flag_out_n_oe_n(err_oe_n));
  // Full wake wait after sleep; it dominates the run time
  step_source ctl (.core_clk(core_clk), .low_power_request_n(low_power_request_n),
    .step_in(step_in));

  initial
  begin
    forever #25 core_clk = ~core_clk;
  end

  task automatic close_out;
    if (fail_count == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      fail_count++;
      close_out();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wr_data <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rd_data;
  endtask

  task automatic set_clear(input logic v);
    @(posedge core_clk);
    chip_clear_n <= v;
    settle(5);
  endtask

  task automatic t_clear_hold;
    ctl.pulse(2, 1'b1);
    check(32'(table_index), 32'h0);
    check(32'(bridge_a_en), 32'h0);
    check(32'(current_a), 32'h64);
    set_clear(1'b1);
    check(32'(bridge_b_en), 32'h1);
  endtask

  task automatic t_index;
    ctl.pulse(6, 1'b0);
    settle(2);
    check(32'(table_index), 32'h60);
    check(32'(current_a), 32'h0);
    check(32'(current_b), 32'hffffff9c);
    reg_read(ADDR_STATE, rd);
    check(32'(rd[6:0]), 32'h60);
    ctl.pulse(2, 1'b0);
    settle(2);
    check(32'(table_index), 32'h0);
    check(32'(current_a), 32'h64);
    @(posedge core_clk);
    step_mode <= MODE_16;
    ctl.pulse(1, 1'b0);
    check(32'(table_index), 32'h2);
    set_clear(1'b0);
    check(32'(table_index), 32'h0);
    set_clear(1'b1);
  endtask

  task automatic t_modes;
    @(posedge core_clk);
    step_mode <= MODE_FULL;
    ctl.pulse(2, 1'b0);
    check(32'(table_index), 32'h30);
    check(32'(current_b), 32'h47);
    @(posedge core_clk);
    step_mode <= MODE_4;
    ctl.pulse(1, 1'b0);
    check(32'(table_index), 32'h38);
    @(posedge core_clk);
    step_mode <= MODE_8;
    ctl.pulse(1, 1'b0);
    check(32'(table_index), 32'h3c);
    @(posedge core_clk);
    step_mode <= 3'h5;
    ctl.pulse(1, 1'b0);
    check(32'(table_index), 32'h3d);
    @(posedge core_clk);
    step_mode <= MODE_FULL;
    ctl.pulse(1, 1'b0);
    check(32'(table_index), 32'h50);
    check(32'(current_a), 32'hffffffb9);
    @(posedge core_clk);
    step_mode <= MODE_16;
    set_clear(1'b0);
    set_clear(1'b1);
  endtask

  task automatic t_enable_irq;
    reg_write(4'hc, 32'hf);
    reg_read(4'hc, rd);
    check(rd, 32'h0);
    reg_write(ADDR_MASK, 32'h8);
    reg_read(ADDR_MASK, rd);
    check(rd, 32'h8);
    reg_read(ADDR_STATUS, rd);
    @(posedge core_clk);
    output_enable_bar <= 1'b1;
    settle(5);
    check(32'(outputs_hiz), 32'h1);
    check(32'(bridge_a_en), 32'h0);
    ctl.pulse(1, 1'b0);
    check(32'(table_index), 32'h0);
    check(32'(irq), 32'h1);
    reg_read(ADDR_STATUS, rd);
    check(32'(rd[EV_DROP]), 32'h1);
    settle(1);
    check(32'(irq), 32'h0);
    @(posedge core_clk);
    output_enable_bar <= 1'b0;
    settle(5);
    check(32'(outputs_hiz), 32'h0);
  endtask

  task automatic t_overcurrent;
    logic [FET_N-1:0] side [2] = '{8'h01, 8'h80};
    for (int i = 0; i < 2; i++)
    begin
      @(posedge core_clk);
      fet_limit <= side[i];
      settle(12);
      check(32'(fault_pin), 32'h0);
      check(32'(bridge_a_en), 32'h0);
      @(posedge core_clk);
      fet_limit <= '0;
      settle(10);
      check(32'(bridge_b_en), 32'h0);
      check(32'(fault_pin), 32'h0);
      set_clear(1'b0);
      set_clear(1'b1);
      check(32'(fault_pin), 32'h1);
      check(32'(bridge_a_en), 32'h1);
    end
  endtask

  task automatic t_thermal;
    @(posedge core_clk);
    die_hot <= 1'b1;
    settle(6);
    check(32'(fault_pin), 32'h0);
    check(32'(bridge_b_en), 32'h0);
    @(posedge core_clk);
    die_hot <= 1'b0;
    settle(6);
    check(32'(fault_pin), 32'h1);
    check(32'(bridge_b_en), 32'h1);
  endtask

  task automatic t_sleep;
    @(posedge core_clk);
    low_power_request_n <= 1'b0;
    settle(6);
    check({29'h0, charge_pump_run, aux_regulator_en, clocks_run}, 32'h0);
    check(32'(bridge_a_en), 32'h0);
    ctl.pulse(1, 1'b1);
    check(32'(table_index), 32'h0);
    @(posedge core_clk);
    low_power_request_n <= 1'b1;
    ctl.pulse(1, 1'b0);
    check(32'(table_index), 32'h2);
    check(32'(charge_pump_run), 32'h1);
  endtask

  task automatic t_lockout;
    @(posedge core_clk);
    supply_low <= 1'b1;
    settle(6);
    check(32'(bridge_a_en), 32'h0);
    check(32'(aux_regulator_en), 32'h0);
    check(32'(table_index), 32'h0);
    @(posedge core_clk);
    supply_low <= 1'b0;
    settle(6);
    check(32'(bridge_a_en), 32'h1);
    reg_write(ADDR_MASK, 32'h4);
    settle(1);
    check(32'(irq), 32'h1);
    reg_read(ADDR_STATUS, rd);
    check(32'(rd[3:0]), 32'h7);
  endtask

  initial
  begin
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    settle(5);
    t_clear_hold();
    t_index();
    t_modes();
    t_enable_irq();
    t_overcurrent();
    t_thermal();
    t_sleep();
    t_lockout();
    close_out();
  end
endmodule
`default_nettype wire
